// ### verilog/afd_params.svh
// Constants for the audio FIFO mover
`ifndef AFD_PARAMS_SVH
`define AFD_PARAMS_SVH
`define AFD_NUM_FIFO      8
`define AFD_FIFO_PER_RAM  4
`define AFD_RAM_AW        10
`define AFD_DATA_W        48
`define AFD_BLKCNT_W      16
`define AFD_BLK_LEN_RST   10'h010
`endif

// ### verilog/afd_pkg.sv
// Types shared by the audio FIFO mover
`include "afd_params.svh"
package afd_pkg;
   typedef struct packed {
      logic                     valid;
      logic                     to_fifo;   // 1: write sample into FIFO, 0: read out
      logic [2:0]               fifo;
      logic [`AFD_DATA_W-1:0]   data;
   } afd_req_t;
   typedef struct packed {
      logic [`AFD_RAM_AW-1:0]   base;
      logic [`AFD_RAM_AW-1:0]   last;
      logic [`AFD_RAM_AW-1:0]   blk_len;
      logic                     enable;
   } afd_cfg_t;
   typedef struct packed {
      logic                     wr;
      logic [`AFD_RAM_AW-1:0]   addr;
      logic [`AFD_DATA_W-1:0]   data;
   } afd_ram_t;
   typedef enum logic [1:0] {AFD_IDLE, AFD_MOVE} afd_state_t;
endpackage : afd_pkg

// ### verilog/afd_fifo_slot.sv
// Pointer and block counter for one FIFO
`include "afd_params.svh"
module afd_fifo_slot
   import afd_pkg::*;
(
   input  wire logic                    clk_i,      // System clock
   input  wire logic                    rst_b_i,    // Async reset, active low
   input  wire afd_cfg_t                cfg_i,      // Region and block length
   input  wire logic                    step_i,     // One sample moved
   output logic [`AFD_RAM_AW-1:0]       ptr_o,      // Current RAM address
   output logic [`AFD_BLKCNT_W-1:0]     blocks_o,   // Completed blocks
   output logic                         blk_done_o  // Pulse on block end
);
   logic [`AFD_RAM_AW-1:0]   ptr, next_ptr, smp, next_smp;
   logic [`AFD_BLKCNT_W-1:0] blocks, next_blocks;
   logic                     done, next_done;
   logic                     en_q;

   always_comb begin
      next_ptr    = ptr;
      next_smp    = smp;
      next_blocks = blocks;
      next_done   = 1'b0;
      if (cfg_i.enable && !en_q) begin
         next_ptr = cfg_i.base;
         next_smp = '0;
      end else if (step_i) begin
         next_ptr = (ptr == cfg_i.last) ? cfg_i.base : ptr + 10'h001;
         next_smp = smp + 10'h001;
         if (next_smp >= cfg_i.blk_len) begin
            next_smp    = '0;
            next_blocks = blocks + 16'h0001;
            next_done   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr    <= '0;
         smp    <= '0;
         blocks <= '0;
         done   <= 1'b0;
         en_q   <= 1'b0;
      end else begin
         ptr    <= next_ptr;
         smp    <= next_smp;
         blocks <= next_blocks;
         done   <= next_done;
         en_q   <= cfg_i.enable;
      end
   end

   assign ptr_o      = ptr;
   assign blocks_o   = blocks;
   assign blk_done_o = done;

   chk_ptr_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      step_i && en_q && ptr == cfg_i.last |=> ptr == $past(cfg_i.base))
      else $error("pointer did not wrap");
   chk_blk_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      done |-> blocks == $past(blocks) + 16'h0001)
      else $error("block end without count");
endmodule : afd_fifo_slot

// ### verilog/afd_dma.sv
// Audio FIFO mover: routes samples into eight circular FIFOs in two RAMs
// Summary of operation
// - Every audio sample transfer is done by hardware, routed per configuration.
// - After setup, samples move in and out of FIFOs without software.
// - Eight FIFOs: four in RAM A, four in RAM B.
// - Each FIFO block counter advances once every blk_len samples moved.
// - Block end raises FIFO interrupt and updates counter; pointers advance on every sample moved.
// - Block interrupts go to the core interrupt controller.
// - Chain controller starts chains on core commands and FIFO block events.
// - Accelerator done events reach the core as interrupts too.
`include "afd_params.svh"
module afd_dma
   import afd_pkg::*;
(
   input  wire logic                          clk_i,          // System clock
   input  wire logic                          rst_b_i,        // Async reset, active low
   input  wire afd_req_t                      req_i,          // Sample request
   output logic                               req_ready_o,    // Request accepted
   input  wire afd_cfg_t [`AFD_NUM_FIFO-1:0]  cfg_i,          // Per FIFO setup
   output afd_ram_t                           ram_a_o,        // fifo_ram_a port
   output logic                               ram_a_en_o,     // fifo_ram_a strobe
   output afd_ram_t                           ram_b_o,        // fifo_ram_b port
   output logic                               ram_b_en_o,     // fifo_ram_b strobe
   input  wire logic [`AFD_DATA_W-1:0]        ram_a_rdata_i,  // fifo_ram_a read data
   input  wire logic [`AFD_DATA_W-1:0]        ram_b_rdata_i,  // fifo_ram_b read data
   output logic [`AFD_DATA_W-1:0]             rd_data_o,      // Sample read out
   output logic                               rd_valid_o,     // Read data valid
   output logic [`AFD_BLKCNT_W-1:0]           blocks_o [`AFD_NUM_FIFO],  // Block counts
   input  wire logic [`AFD_NUM_FIFO-1:0]      chain_en_i,     // Chain trigger enables
   input  wire logic [`AFD_NUM_FIFO-1:0]      core_cmd_i,     // Core chain start cmds
   input  wire logic                          accel_done_i,   // Accelerator done event
   output logic [`AFD_NUM_FIFO-1:0]           fifo_irq_o,     // FIFO block interrupts
   output logic                               accel_irq_o,    // Accelerator interrupt
   output logic [`AFD_NUM_FIFO-1:0]           chain_start_o   // Chain start pulses
);
   afd_state_t               state, next_state;
   logic [2:0]               rd_fifo, next_rd_fifo;
   logic [`AFD_NUM_FIFO-1:0] step, blk_done;
   logic [`AFD_RAM_AW-1:0]   ptr [`AFD_NUM_FIFO];
   afd_ram_t                 next_ram_a, next_ram_b, ram_a, ram_b;
   logic                     next_a_en, next_b_en, a_en, b_en;
   logic [`AFD_DATA_W-1:0]   rd_data, next_rd_data;
   logic                     rd_valid, next_rd_valid;
   logic [`AFD_NUM_FIFO-1:0] irq, next_irq, chain, next_chain;
   logic                     accel, next_accel;

   // Upper half of the FIFO index selects RAM B
   function automatic logic in_ram_b(input logic [2:0] f);
      return f >= 3'(`AFD_FIFO_PER_RAM);
   endfunction : in_ram_b

   // One request per cycle; a read takes a second cycle for RAM data to return
   assign req_ready_o = (state == AFD_IDLE);

   always_comb begin
      next_state    = state;
      next_rd_fifo  = rd_fifo;
      next_ram_a    = ram_a;
      next_ram_b    = ram_b;
      next_a_en     = 1'b0;
      next_b_en     = 1'b0;
      next_rd_data  = rd_data;
      next_rd_valid = 1'b0;
      step          = '0;
      unique case (state)
         AFD_IDLE: begin
            if (req_i.valid && cfg_i[req_i.fifo].enable) begin
               step[req_i.fifo] = 1'b1;
               if (in_ram_b(req_i.fifo)) begin
                  next_b_en  = 1'b1;
                  next_ram_b = '{wr: req_i.to_fifo, addr: ptr[req_i.fifo], data: req_i.data};
               end else begin
                  next_a_en  = 1'b1;
                  next_ram_a = '{wr: req_i.to_fifo, addr: ptr[req_i.fifo], data: req_i.data};
               end
               if (!req_i.to_fifo) begin
                  next_rd_fifo = req_i.fifo;
                  next_state   = AFD_MOVE;
               end
            end
         end
         AFD_MOVE: begin
            next_rd_data  = in_ram_b(rd_fifo) ? ram_b_rdata_i : ram_a_rdata_i;
            next_rd_valid = 1'b1;
            next_state    = AFD_IDLE;
         end
         default: next_state = AFD_IDLE;
      endcase
   end

   always_comb begin
      next_irq   = blk_done;
      next_chain = (blk_done & chain_en_i) | core_cmd_i;
      next_accel = accel_done_i;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state    <= AFD_IDLE;
         rd_fifo  <= '0;
         ram_a    <= '0;
         ram_b    <= '0;
         a_en     <= 1'b0;
         b_en     <= 1'b0;
         rd_data  <= '0;
         rd_valid <= 1'b0;
         irq      <= '0;
         chain    <= '0;
         accel    <= 1'b0;
      end else begin
         state    <= next_state;
         rd_fifo  <= next_rd_fifo;
         ram_a    <= next_ram_a;
         ram_b    <= next_ram_b;
         a_en     <= next_a_en;
         b_en     <= next_b_en;
         rd_data  <= next_rd_data;
         rd_valid <= next_rd_valid;
         irq      <= next_irq;
         chain    <= next_chain;
         accel    <= next_accel;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `AFD_NUM_FIFO; g++) begin : g_slot
         afd_fifo_slot u_slot (
            .clk_i      (clk_i),
            .rst_b_i    (rst_b_i),
            .cfg_i      (cfg_i[g]),
            .step_i     (step[g]),
            .ptr_o      (ptr[g]),
            .blocks_o   (blocks_o[g]),
            .blk_done_o (blk_done[g])
         );
      end
   endgenerate

   assign ram_a_o       = ram_a;
   assign ram_a_en_o    = a_en;
   assign ram_b_o       = ram_b;
   assign ram_b_en_o    = b_en;
   assign rd_data_o     = rd_data;
   assign rd_valid_o    = rd_valid;
   assign fifo_irq_o    = irq;
   assign accel_irq_o   = accel;
   assign chain_start_o = chain;

   sequence s_read_req;
      req_i.valid && req_ready_o && !req_i.to_fifo && cfg_i[req_i.fifo].enable;
   endsequence
   sequence s_read_done;
      ##2 rd_valid_o;
   endsequence

   chk_read_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_read_req |-> s_read_done)
      else $error("read data not returned in two cycles");
   chk_ram_route: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      req_i.valid && req_ready_o && cfg_i[req_i.fifo].enable
      |=> (b_en == $past(in_ram_b(req_i.fifo))) && (a_en != b_en))
      else $error("sample sent to wrong RAM");
   chk_no_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !(req_i.valid && req_ready_o) |=> !a_en && !b_en)
      else $error("RAM strobed without request");
   chk_irq_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      |blk_done |=> fifo_irq_o == $past(blk_done))
      else $error("block interrupt missing");
   chk_irq_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      blk_done == '0 |=> fifo_irq_o == '0)
      else $error("spurious block interrupt");
   chk_chain_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      core_cmd_i == '0 |=> (chain_start_o & ~$past(chain_en_i)) == '0)
      else $error("chain started while disabled");
   chk_chain_evt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      |(blk_done & chain_en_i) |=> (chain_start_o & $past(blk_done & chain_en_i)) != '0)
      else $error("enabled chain not started");
   chk_accel_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      accel_done_i |=> accel_irq_o)
      else $error("accelerator interrupt missing");
endmodule : afd_dma

// ### verification/afd_far_model.sv
// Far side model: both FIFO RAMs plus interrupt and chain-start counters
`include "afd_params.svh"
module afd_far_model
   import afd_pkg::*;
(
   input  wire logic                     clk_i,       // System clock
   input  wire afd_ram_t                 ram_a_i,     // fifo_ram_a port
   input  wire logic                     ram_a_en_i,  // fifo_ram_a strobe
   input  wire afd_ram_t                 ram_b_i,     // fifo_ram_b port
   input  wire logic                     ram_b_en_i,  // fifo_ram_b strobe
   output logic [`AFD_DATA_W-1:0]        rdata_a_o,   // fifo_ram_a read data
   output logic [`AFD_DATA_W-1:0]        rdata_b_o,   // fifo_ram_b read data
   input  wire logic [`AFD_NUM_FIFO-1:0] irq_i,       // FIFO interrupts
   input  wire logic                     accel_irq_i, // Accelerator interrupt
   input  wire logic [`AFD_NUM_FIFO-1:0] chain_i,     // Chain starts
   output int                            n_irq_o [8], // Interrupts seen
   output int                            n_chain_o [8], // Chains started
   output int                            n_accel_o    // Accelerator interrupts
);
   timeunit 1ns;
   timeprecision 1ps;
   bit [`AFD_DATA_W-1:0] mem [2][1024];
   bit [`AFD_DATA_W-1:0] junk = 48'h5A5A_A5A5_0F0F;
   // Asynchronous read: data stands only while a read strobe does; otherwise it
   // toggles, so a sample taken in the wrong cycle shows up as a mismatch
   always @(posedge clk_i) begin
      if (ram_a_en_i && ram_a_i.wr)
         mem[0][ram_a_i.addr] <= ram_a_i.data;
      if (ram_b_en_i && ram_b_i.wr)
         mem[1][ram_b_i.addr] <= ram_b_i.data;
      junk <= ~junk;
   end
   assign rdata_a_o = (ram_a_en_i && !ram_a_i.wr) ? mem[0][ram_a_i.addr] : junk;
   assign rdata_b_o = (ram_b_en_i && !ram_b_i.wr) ? mem[1][ram_b_i.addr] : ~junk;
   always @(posedge clk_i) begin
      for (int f = 0; f < 8; f++) begin
         n_irq_o[f] <= n_irq_o[f] + int'(irq_i[f] === 1'b1);
         n_chain_o[f] <= n_chain_o[f] + int'(chain_i[f] === 1'b1);
      end
      n_accel_o <= n_accel_o + int'(accel_irq_i === 1'b1);
   end
endmodule : afd_far_model

// ### verification/tb.sv
// Self-checking bench for the audio FIFO mover
`include "afd_params.svh"
module tb
   import afd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_i = 1'b0;
   logic                 rst_b_i = 1'b0;
   afd_req_t             req;
   afd_cfg_t [7:0]       cfg;
   afd_ram_t             ram_a, ram_b;
   logic                 ram_a_en, ram_b_en, req_ready, rd_valid, accel_irq;
   logic                 accel_done = 1'b0;
   logic [47:0]          rdata_a, rdata_b, rd_data, exp;
   logic [15:0]          blocks [8];
   logic [7:0]           chain_en, irq, chain;
   logic [7:0]           core_cmd = 8'h00;
   int                   n_irq [8], n_chain [8], n_accel, errors, n_compared;
   int                   ptr [8], cnt [8], blk [8], e_chain [8], e_accel;
   bit [47:0]            mem [2][1024];

   afd_dma dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .req_ready_o(req_ready),
      .cfg_i(cfg), .ram_a_o(ram_a), .ram_a_en_o(ram_a_en), .ram_b_o(ram_b),
      .ram_b_en_o(ram_b_en), .ram_a_rdata_i(rdata_a), .ram_b_rdata_i(rdata_b),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .blocks_o(blocks), .chain_en_i(chain_en),
      .core_cmd_i(core_cmd), .accel_done_i(accel_done), .fifo_irq_o(irq),
      .accel_irq_o(accel_irq), .chain_start_o(chain));
   afd_far_model far (.clk_i(clk_i), .ram_a_i(ram_a), .ram_a_en_i(ram_a_en),
      .ram_b_i(ram_b), .ram_b_en_i(ram_b_en), .rdata_a_o(rdata_a), .rdata_b_o(rdata_b),
      .irq_i(irq), .accel_irq_i(accel_irq), .chain_i(chain), .n_irq_o(n_irq),
      .n_chain_o(n_chain), .n_accel_o(n_accel));

   initial forever #10 clk_i = ~clk_i;

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_compared++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic give_verdict;
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   // One sample request, entered and left on a falling edge
   task automatic op(input int f, input bit wr, input logic [47:0] d);
      int r;
      r = f / 4;
      check(req_ready, 1'b1);
      req = '{1'b1, wr, 3'(f), d};
      @(negedge clk_i);
      req.valid = 1'b0;
      if (!cfg[f].enable)
         check({ram_a_en, ram_b_en}, 2'b00);
      else begin
         check(r ? {ram_b_en, ram_b.wr, ram_b.addr} : {ram_a_en, ram_a.wr, ram_a.addr},
               {1'b1, wr, 10'(ptr[f])});
         if (wr)
            mem[r][ptr[f]] = d;
         else
            check(req_ready, 1'b0);
         exp = mem[r][ptr[f]];
         ptr[f] = (ptr[f] == cfg[f].last) ? int'(cfg[f].base) : ptr[f] + 1;
         cnt[f]++;
         if (cnt[f] % 4 == 0) begin
            blk[f]++;
            e_chain[f] += int'(chain_en[f]);
         end
         if (!wr) begin
            @(negedge clk_i);
            check({rd_valid, rd_data}, {1'b1, exp});
         end
      end
      repeat (3) @(negedge clk_i);
      check(blocks[f], 16'(blk[f]));
      check(n_irq[f], blk[f]);
      check(n_chain[f], e_chain[f]);
   endtask : op

   initial begin
      void'($urandom(26));
      req = '0;
      chain_en = 8'h00;
      for (int f = 0; f < 8; f++) begin
         cfg[f] = '{10'((f % 4) * 64), 10'((f % 4) * 64 + 7), 10'h004, 1'b0};
         ptr[f] = (f % 4) * 64;
      end
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      check({irq, chain, rd_valid, ram_a_en, ram_b_en, accel_irq}, 20'h00000);
      rst_b_i = 1'b1;
      chain_en = 8'($urandom);
      for (int f = 0; f < 8; f++)
         cfg[f].enable = 1'b1;
      @(negedge clk_i);
      check(req_ready, 1'b1);
      // Nine writes wrap the eight-word region; five reads end a third block
      for (int f = 0; f < 8; f++) begin
         repeat (9) op(f, 1'b1, 48'({$urandom, $urandom}));
         repeat (5) op(f, 1'b0, 48'h0);
      end
      core_cmd = 8'($urandom);
      accel_done = 1'b1;
      for (int f = 0; f < 8; f++)
         e_chain[f] += int'(core_cmd[f]);
      e_accel++;
      @(negedge clk_i);
      core_cmd = 8'h00;
      accel_done = 1'b0;
      repeat (3) @(negedge clk_i);
      for (int f = 0; f < 8; f++)
         check(n_chain[f], e_chain[f]);
      check(n_accel, e_accel);
      cfg[5].enable = 1'b0;
      @(negedge clk_i);
      op(5, 1'b1, 48'h0000_0000_ABCD);
      // Re-enabling reloads the pointer to the region start and restarts the block
      cfg[5].enable = 1'b1;
      ptr[5] = int'(cfg[5].base);
      cnt[5] = 0;
      @(negedge clk_i);
      op(5, 1'b1, 48'h0000_0000_1234);
      give_verdict();
   end

   initial begin
      #100us;
      errors++;
      give_verdict();
   end
endmodule : tb
